// *** src/ang_ability_regs.sv ***
// Summary of operation
// R1: advertised next-page bit always reads 0
// R2: acknowledge bit sets once partner page accepted
// R3: writable remote-fault advertisement bit, reset 0
// R4: reserved bits written 0, read ignored
// R5: writable pause advertisement bit, reset 0
// R6: advertised T4 ability fixed at 0
// R7: fast full and half bits writable, reset 1
// R8: ten full and half bits writable
// R9: writable selector field, resets to 00001
// R10: advertisement word resets to 01e1
// R11: partner next-page, ack, fault bits from page
// R12: partner pause and T4 bits from page
// R13: partner fast and ten duplex bits from page
// R14: partner selector field from page, reset 0
// R15: parallel-detection fault flag latches high
// R16: expansion shows partner next-page ability
// R17: own next-page ability reads 0
// R18: page-received flag latches on new page
// R19: partner auto-negotiation capable bit
// R20: partner and expansion words reset zero
// R21: latched bits clear on read or reset
// R22: answers only frames for its PHY address
// R23: opcode 10 reads, opcode 01 writes
// R24: whole partner page updates in one cycle
`include "ang_regs.svh"

module ang_ability_regs
    import ang_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // management pins
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    // auto-negotiation engine
    input wire logic pageAccept,
    input wire logic [15:0] pageWord,
    input wire logic parallelFault,
    input wire logic anRestart,
    // abilities to advertise
    output logic [15:0] advertWord
);

    function automatic logic [15:0] regRead(input logic [4:0] addr, input logic [15:0] adv,
        input logic [15:0] part, input logic [15:0] expn);
        logic [15:0] value;
        unique case (addr)
            `ANG_REG_ADVERT: value = adv;
            `ANG_REG_PARTNER: value = part;
            `ANG_REG_EXPANSION: value = expn;
            default: value = 16'h0000;
        endcase
        return value;
    endfunction : regRead

    logic mdcRise, bitIn;

    ang_mdc_sampler #(
        .STAGES(2)
    ) sampler (
        .clock(clock),
        .sys_rst(sys_rst),
        .mdc(mdc),
        .mdioIn(mdioIn),
        .mdcRise(mdcRise),
        .mdioBit(bitIn)
    );

    ang_state_type state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [15:0] shift_reg, shift_next;
    logic [1:0] op_reg, op_next;
    logic [4:0] phy_reg, phy_next;
    logic [4:0] addr_reg, addr_next;
    logic mine_reg, mine_next;
    logic mdioOut_reg, mdioOut_next;
    logic mdioOe_reg, mdioOe_next;
    logic [15:0] advert_reg, advert_next;
    logic ackSeen_reg, ackSeen_next;
    logic [15:0] partner_reg, partner_next;
    logic parFault_reg, parFault_next;
    logic lpNpAble_reg, lpNpAble_next;
    logic pageRecv_reg, pageRecv_next;
    logic lpAnAble_reg, lpAnAble_next;
    logic [4:0] fullAddr;
    logic [15:0] wrData, advertView, expansionView;
    logic readFire, writeFire, readExp, wrAdvert;

    assign fullAddr = {addr_reg[3:0], bitIn};
    assign wrData = {shift_reg[14:0], bitIn};

    // R1: next page never offered
    // R6: t4 never offered
    // R2: acknowledge shown over stored bits
    always_comb
    begin
        advertView = advert_reg & `ANG_ADVERT_WMASK;
        advertView[`ANG_BIT_ACK] = ackSeen_reg;
        advertView[`ANG_BIT_NEXT_PAGE] = 1'b0;
        expansionView = `ANG_EXPANSION_RESET;
        expansionView[`ANG_EXP_PAR_FAULT] = parFault_reg;
        expansionView[`ANG_EXP_LP_NP_ABLE] = lpNpAble_reg;
        // R17: own next-page ability reads 0
        expansionView[`ANG_EXP_NP_ABLE] = 1'b0;
        expansionView[`ANG_EXP_NEW_PAGE_FLAG] = pageRecv_reg;
        expansionView[`ANG_EXP_LP_AN_ABLE] = lpAnAble_reg;
    end

    // frame decoder, advanced once per mdc rising edge
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        op_next = op_reg;
        phy_next = phy_reg;
        addr_next = addr_reg;
        mine_next = mine_reg;
        mdioOut_next = mdioOut_reg;
        mdioOe_next = mdioOe_reg;
        readFire = 1'b0;
        writeFire = 1'b0;
        if (mdcRise)
        begin
            unique case (state_reg)
                ST_IDLE:
                    // preamble optional: a zero on an idle line opens a frame
                    if (!bitIn)
                        state_next = ST_START;
                ST_START:
                    if (bitIn)
                    begin
                        state_next = ST_OPCODE;
                        cnt_next = `ANG_CNT_OP;
                    end
                ST_OPCODE:
                begin
                    op_next = {op_reg[0], bitIn};
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0)
                    begin
                        state_next = ST_PHYAD;
                        cnt_next = `ANG_CNT_ADDR;
                    end
                end
                ST_PHYAD:
                begin
                    phy_next = {phy_reg[3:0], bitIn};
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0)
                    begin
                        state_next = ST_REGAD;
                        cnt_next = `ANG_CNT_ADDR;
                    end
                end
                ST_REGAD:
                begin
                    addr_next = fullAddr;
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0)
                    begin
                        state_next = ST_TURN;
                        cnt_next = `ANG_CNT_TA;
                        // R22: foreign frames are tracked but never answered
                        // R23: only the two defined opcodes are served
                        mine_next = (phy_reg == `ANG_PHY_ADDR)
                            && ((op_reg == `ANG_OP_READ) || (op_reg == `ANG_OP_WRITE));
                        if (mine_next && (op_reg == `ANG_OP_READ))
                        begin
                            readFire = 1'b1;
                            shift_next = regRead(fullAddr, advertView, partner_reg, expansionView);
                        end
                    end
                end
                ST_TURN:
                begin
                    cnt_next = cnt_reg - 4'h1;
                    if (mine_reg && (op_reg == `ANG_OP_READ))
                    begin
                        // first turnaround bit undriven, second driven low
                        mdioOe_next = 1'b1;
                        mdioOut_next = 1'b0;
                        if (cnt_reg == 4'h0)
                        begin
                            mdioOut_next = shift_reg[15];
                            shift_next = {shift_reg[14:0], 1'b0};
                        end
                    end
                    if (cnt_reg == 4'h0)
                    begin
                        cnt_next = `ANG_CNT_DATA;
                        state_next = (op_reg == `ANG_OP_READ) ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    shift_next = wrData;
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0)
                    begin
                        state_next = ST_IDLE;
                        writeFire = mine_reg && (op_reg == `ANG_OP_WRITE);
                    end
                end
                ST_READ:
                begin
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0)
                    begin
                        state_next = ST_IDLE;
                        mdioOe_next = 1'b0;
                    end
                    else if (mdioOe_reg)
                    begin
                        mdioOut_next = shift_reg[15];
                        shift_next = {shift_reg[14:0], 1'b0};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 16'h0000;
            op_reg <= 2'h0;
            phy_reg <= 5'h00;
            addr_reg <= 5'h00;
            mine_reg <= 1'b0;
            mdioOut_reg <= 1'b0;
            mdioOe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            op_reg <= op_next;
            phy_reg <= phy_next;
            addr_reg <= addr_next;
            mine_reg <= mine_next;
            mdioOut_reg <= mdioOut_next;
            mdioOe_reg <= mdioOe_next;
        end
    end

    assign readExp = readFire && (fullAddr == `ANG_REG_EXPANSION);
    assign wrAdvert = writeFire && (addr_reg == `ANG_REG_ADVERT);

    // register contents
    always_comb
    begin
        advert_next = advert_reg;
        partner_next = partner_reg;
        lpNpAble_next = lpNpAble_reg;
        lpAnAble_next = lpAnAble_reg;
        // R3: remote fault, R5: pause, R7: fast modes, R8: ten modes, R9: selector
        // R4: reserved and fixed bits are not stored
        if (wrAdvert)
            advert_next = wrData & `ANG_ADVERT_WMASK;
        // R2: restart withdraws the acknowledge, a new page wins over it
        ackSeen_next = (ackSeen_reg && !anRestart) || pageAccept;
        // R24: all partner fields move together with the flag
        if (pageAccept)
        begin
            // R11: np, ack, fault; R12: pause, t4; R13: duplex; R14: selector
            partner_next = pageWord & `ANG_PARTNER_MASK;
            // R16: partner next-page ability
            lpNpAble_next = pageWord[`ANG_BIT_NEXT_PAGE];
            // R19: a base page proves the partner negotiates
            lpAnAble_next = 1'b1;
        end
        // R18: page received latches
        // R21: read clears, set wins in the same cycle
        pageRecv_next = (pageRecv_reg && !readExp) || pageAccept;
        // R15: parallel detection fault latches
        parFault_next = (parFault_reg && !readExp) || parallelFault;
    end

    // R10: advertisement default
    // R20: partner and expansion zero
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            advert_reg <= `ANG_ADVERT_RESET;
            ackSeen_reg <= 1'b0;
            partner_reg <= `ANG_PARTNER_RESET;
            parFault_reg <= 1'b0;
            lpNpAble_reg <= 1'b0;
            pageRecv_reg <= 1'b0;
            lpAnAble_reg <= 1'b0;
        end
        else
        begin
            advert_reg <= advert_next;
            ackSeen_reg <= ackSeen_next;
            partner_reg <= partner_next;
            parFault_reg <= parFault_next;
            lpNpAble_reg <= lpNpAble_next;
            pageRecv_reg <= pageRecv_next;
            lpAnAble_reg <= lpAnAble_next;
        end
    end

    assign mdioOut = mdioOut_reg;
    assign mdioOe = mdioOe_reg;
    assign advertWord = advertView;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    sequence s_pageIn;
        pageAccept ##1 1'b1;
    endsequence
    sequence s_expRead;
        readExp && !pageAccept && !parallelFault;
    endsequence
    // rise that ends the first turnaround bit of an own read
    sequence s_turnFirst;
        mdcRise && state_reg == ST_TURN && cnt_reg == `ANG_CNT_TA && mine_reg && op_reg == `ANG_OP_READ;
    endsequence
    a_fixed_zero: assert property ( // R1
        !advertWord[`ANG_BIT_NEXT_PAGE] && !advertWord[`ANG_BIT_T4] && !expansionView[`ANG_EXP_NP_ABLE])
        else $error("fixed zero bits read as one");
    a_ack_set: assert property ( // R2
        (pageAccept || anRestart) |=> advertWord[`ANG_BIT_ACK] == $past(pageAccept))
        else $error("acknowledge not set or cleared");
    a_advert_write: assert property ( // R3
        wrAdvert |=> advert_reg == ($past(wrData) & `ANG_ADVERT_WMASK))
        else $error("advertisement write not stored");
    a_reserved_zero: assert property ( // R4
        (advertWord & `ANG_RSVD_LOW_MASK) == 16'h0000 && (partner_reg & `ANG_RSVD_LOW_MASK) == 16'h0000
        && (expansionView & `ANG_RSVD_EXP_MASK) == 16'h0000)
        else $error("reserved bits not zero");
    a_reset_values: assert property (@(posedge clock) disable iff (1'b0) // R10
        sys_rst |=> advertWord == `ANG_ADVERT_RESET && partner_reg == `ANG_PARTNER_RESET
        && expansionView == `ANG_EXPANSION_RESET)
        else $error("wrong value after reset");
    a_page_load: assert property ( // R24
        s_pageIn |-> partner_reg == ($past(pageWord, 1) & `ANG_PARTNER_MASK)
        && pageRecv_reg && lpAnAble_reg && lpNpAble_reg == $past(pageWord[`ANG_BIT_NEXT_PAGE], 1))
        else $error("partner page not taken whole");
    a_fault_latch: assert property ( // R15
        parallelFault ##1 (!readExp)[*3] |-> parFault_reg)
        else $error("parallel fault flag lost");
    a_read_clears: assert property ( // R21
        s_expRead |=> !pageRecv_reg && !parFault_reg)
        else $error("latched flags not cleared by read");
    a_drive_owner: assert property ( // R22
        mdioOe |-> mine_reg && op_reg == `ANG_OP_READ)
        else $error("drives the line outside an own read");
    a_read_turn: assert property ( // R23
        s_turnFirst |-> !mdioOe ##1 (mdioOe && !mdioOut))
        else $error("turnaround not as expected");
endmodule : ang_ability_regs

// *** src/ang_regs.svh ***
`ifndef ANG_REGS_SVH
`define ANG_REGS_SVH

// management frame addressing
`define ANG_PHY_ADDR 5'h10
`define ANG_OP_READ 2'h2
`define ANG_OP_WRITE 2'h1

// register addresses
`define ANG_REG_ADVERT 5'h04
`define ANG_REG_PARTNER 5'h05
`define ANG_REG_EXPANSION 5'h06

// reset values
`define ANG_ADVERT_RESET 16'h01e1
`define ANG_PARTNER_RESET 16'h0000
`define ANG_EXPANSION_RESET 16'h0000

// writable bits of the advertisement word: 13, 10, 8..0
`define ANG_ADVERT_WMASK 16'h25ff
// stored bits of the partner base page: all but 12..11
`define ANG_PARTNER_MASK 16'he7ff

// field positions
`define ANG_BIT_NEXT_PAGE 15
`define ANG_BIT_ACK 14
`define ANG_BIT_T4 9
// reserved bits: 12..11 of advert and partner words, 15..5 of expansion
`define ANG_RSVD_LOW_MASK 16'h1800
`define ANG_RSVD_EXP_MASK 16'hffe0
`define ANG_EXP_PAR_FAULT 4
`define ANG_EXP_LP_NP_ABLE 3
`define ANG_EXP_NP_ABLE 2
`define ANG_EXP_NEW_PAGE_FLAG 1
`define ANG_EXP_LP_AN_ABLE 0

// frame field lengths less one, as down-counter start values
`define ANG_CNT_OP 4'h1
`define ANG_CNT_ADDR 4'h4
`define ANG_CNT_TA 4'h1
`define ANG_CNT_DATA 4'hf

`endif

// *** src/ang_pkg.sv ***
package ang_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_OPCODE,
        ST_PHYAD,
        ST_REGAD,
        ST_TURN,
        ST_WRITE,
        ST_READ
    } ang_state_type;

endpackage : ang_pkg

// *** src/ang_mdc_sampler.sv ***
module ang_mdc_sampler #(
    parameter int STAGES = 2
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // pins from the management link
    input wire logic mdc,
    input wire logic mdioIn,
    // sampled view
    output logic mdcRise,
    output logic mdioBit
);

    if (STAGES < 2)
    begin : g_bad_stages
        $error("ang_mdc_sampler needs at least two stages");
    end

    logic [STAGES-1:0] mdcSync_reg;
    logic [STAGES-1:0] mdcSync_next;
    logic [STAGES-1:0] mdioSync_reg;
    logic [STAGES-1:0] mdioSync_next;
    logic mdcLast_reg;
    logic mdcLast_next;

    always_comb
    begin
        mdcSync_next = {mdcSync_reg[STAGES-2:0], mdc};
        mdioSync_next = {mdioSync_reg[STAGES-2:0], mdioIn};
        mdcLast_next = mdcSync_reg[STAGES-1];
    end

    // idle level of mdio is high and a reset high on mdc cannot fake a rise, so reset to ones
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mdcSync_reg <= '1;
            mdioSync_reg <= '1;
            mdcLast_reg <= 1'b1;
        end
        else
        begin
            mdcSync_reg <= mdcSync_next;
            mdioSync_reg <= mdioSync_next;
            mdcLast_reg <= mdcLast_next;
        end
    end

    assign mdcRise = mdcSync_reg[STAGES-1] & ~mdcLast_reg;
    assign mdioBit = mdioSync_reg[STAGES-1];

endmodule : ang_mdc_sampler

// *** bench/ang_station_model.sv ***
module ang_station_model
(
    // management pins
    output logic mdc,
    output logic mdioDrive,
    output logic mdioDriveOe,
    // resolved line, pulled up when nobody drives
    input wire logic mdioLine
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        mdc = 1'b0;
        mdioDrive = 1'b1;
        mdioDriveOe = 1'b0;
    end

    // data changes while mdc is low, well ahead of the rise
    task automatic send_bit(input logic b);
        mdioDriveOe = 1'b1;
        mdioDrive = b;
        #100 mdc = 1'b1;
        #100 mdc = 1'b0;
    endtask : send_bit

    // sampled just before the rise, a half period after mdc fell
    task automatic take_bit(output logic b);
        mdioDriveOe = 1'b0;
        #100 b = mdioLine;
        mdc = 1'b1;
        #100 mdc = 1'b0;
    endtask : take_bit

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regAddr,
                         input logic [15:0] wdata, output logic [15:0] rdata, output logic taBit);
        logic [13:0] head;
        logic b;
        head = {2'b01, op, phy, regAddr};
        rdata = 16'h0000;
        taBit = 1'b1;
        repeat (32) send_bit(1'b1);
        for (int i = 13; i >= 0; i--)
            send_bit(head[i]);
        if (op == 2'b10)
        begin
            take_bit(b);
            take_bit(taBit);
            for (int i = 15; i >= 0; i--)
                take_bit(rdata[i]);
        end
        else
        begin
            send_bit(1'b1);
            send_bit(1'b0);
            for (int i = 15; i >= 0; i--)
                send_bit(wdata[i]);
        end
        // clock stands still between frames, line released
        mdioDriveOe = 1'b0;
        #400;
    endtask : frame
endmodule : ang_station_model

// *** bench/ang_ability_regs_bench.sv ***
`define CHECK(name, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("mismatch %s expected %h seen %h", name, exp, got); \
        end \
    end

module ang_ability_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // bits 13, 10 and 8..0 of the advertisement word are writable
    localparam logic [15:0] advWritable = 16'h25ff;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic mdc, mdioIn, mdioOut, mdioOe, stationDrive, stationOe, ta;
    logic pageAccept, parallelFault, anRestart;
    logic [15:0] pageWord, advertWord, rd;
    int errors = 0;
    int checks = 0;
    int oeCount = 0;
    int oeMark;

    always #12.5 clock = ~clock;

    assign mdioIn = mdioOe ? mdioOut : (stationOe ? stationDrive : 1'b1);

    // clock cycles in which the device drives the line
    always @(posedge clock)
        if (mdioOe === 1'b1)
            oeCount <= oeCount + 1;

    ang_ability_regs dut (
        .clock(clock),
        .sys_rst(sys_rst),
        .mdc(mdc),
        .mdioIn(mdioIn),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe),
        .pageAccept(pageAccept),
        .pageWord(pageWord),
        .parallelFault(parallelFault),
        .anRestart(anRestart),
        .advertWord(advertWord)
    );

    ang_station_model station (
        .mdc(mdc),
        .mdioDrive(stationDrive),
        .mdioDriveOe(stationOe),
        .mdioLine(mdioIn)
    );

    task automatic stop_test;
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // reserved read bits carry no meaning, so they are masked off
    task automatic chk_read(input string name, input logic [4:0] a, input logic [15:0] exp,
                            input logic [15:0] mask);
        station.frame(2'b10, 5'h10, a, 16'h0000, rd, ta);
        `CHECK(name, exp & mask, rd & mask)
    endtask : chk_read

    task automatic wr_reg(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] a,
                          input logic [15:0] d);
        station.frame(op, phy, a, d, rd, ta);
    endtask : wr_reg

    // word is scrambled after the accept cycle to show it was captured
    task automatic page(input logic [15:0] w);
        @(negedge clock);
        pageAccept = 1'b1;
        pageWord = w;
        @(negedge clock);
        pageAccept = 1'b0;
        pageWord = ~w;
        `CHECK("ack after page", 1'b1, advertWord[14])
    endtask : page

    task automatic pulse_fault;
        @(negedge clock);
        parallelFault = 1'b1;
        @(negedge clock);
        parallelFault = 1'b0;
    endtask : pulse_fault

    initial
    begin
        repeat (40000) @(posedge clock);
        errors++;
        stop_test();
    end

    initial
    begin
        pageAccept = 1'b0;
        pageWord = 16'h0000;
        parallelFault = 1'b0;
        anRestart = 1'b0;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        `CHECK("advertWord reset", 16'h01e1, advertWord)
        chk_read("advert reset", 5'h04, 16'h01e1, 16'he7ff);
        `CHECK("turnaround", 1'b0, ta)
        chk_read("partner reset", 5'h05, 16'h0000, 16'he7ff);
        chk_read("expansion reset", 5'h06, 16'h0000, 16'h001f);
        wr_reg(2'b01, 5'h10, 5'h04, 16'he7ff);
        chk_read("advert all set", 5'h04, 16'he7ff & advWritable, 16'he7ff);
        `CHECK("advertWord all set", 16'h25ff, advertWord)
        wr_reg(2'b01, 5'h10, 5'h04, 16'h0000);
        chk_read("advert cleared", 5'h04, 16'h0000, 16'he7ff);
        // foreign address and unused opcodes must leave the word alone
        wr_reg(2'b01, 5'h11, 5'h04, 16'h25ff);
        wr_reg(2'b11, 5'h10, 5'h04, 16'h25ff);
        wr_reg(2'b00, 5'h10, 5'h04, 16'h25ff);
        chk_read("advert untouched", 5'h04, 16'h0000, 16'he7ff);
        oeMark = oeCount;
        station.frame(2'b10, 5'h11, 5'h04, 16'h0000, rd, ta);
        `CHECK("foreign read drive", oeMark, oeCount)
        `CHECK("foreign read line", 16'hffff, rd)
        wr_reg(2'b01, 5'h10, 5'h05, 16'he7ff);
        wr_reg(2'b01, 5'h10, 5'h06, 16'h001f);
        chk_read("partner not writable", 5'h05, 16'h0000, 16'he7ff);
        chk_read("expansion not writable", 5'h06, 16'h0000, 16'h001f);
        // own read drives from second turnaround bit to end of data: 17 bit times of 8 clocks
        oeMark = oeCount;
        chk_read("unmapped", 5'h07, 16'h0000, 16'hffff);
        `CHECK("own read drive", oeMark + 136, oeCount)
        page(16'he7ff);
        chk_read("ack in advert", 5'h04, 16'h4000, 16'he7ff);
        chk_read("partner page a", 5'h05, 16'he7ff, 16'he7ff);
        chk_read("expansion page a", 5'h06, 16'h000b, 16'h001f);
        chk_read("expansion cleared a", 5'h06, 16'h0009, 16'h001f);
        page(16'h0421);
        chk_read("partner page b", 5'h05, 16'h0421, 16'he7ff);
        chk_read("expansion page b", 5'h06, 16'h0003, 16'h001f);
        chk_read("expansion cleared b", 5'h06, 16'h0001, 16'h001f);
        @(negedge clock);
        anRestart = 1'b1;
        @(negedge clock);
        anRestart = 1'b0;
        `CHECK("ack after restart", 1'b0, advertWord[14])
        pulse_fault();
        repeat (20) @(negedge clock);
        chk_read("fault latched", 5'h06, 16'h0011, 16'h001f);
        chk_read("fault cleared", 5'h06, 16'h0001, 16'h001f);
        wr_reg(2'b01, 5'h10, 5'h04, 16'h0060);
        chk_read("ten modes", 5'h04, 16'h0060, 16'he7ff);
        // second reset in mid-run wipes latched and captured state
        pulse_fault();
        page(16'h8021);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        `CHECK("advertWord rereset", 16'h01e1, advertWord)
        chk_read("expansion rereset", 5'h06, 16'h0000, 16'h001f);
        chk_read("partner rereset", 5'h05, 16'h0000, 16'he7ff);
        stop_test();
    end
endmodule : ang_ability_regs_bench
